// ### verilog/tdf_pkg.sv
// Shared constants and types for the transmit descriptor fetch engine and its host end.
// Assumes one clock hclk and one asynchronous active-low reset hresetn for both ends.
package tdf_pkg;
    // ============================================================
    // Command queue and descriptor geometry
    localparam int CMD_DEPTH = 8;
    localparam int CNT_W = 4;
    localparam int MAX_FRAGS = 31;
    localparam logic [15:0] MAX_PKT_LEN = 16'h8000;
    localparam logic [63:0] HDR_BYTES = 64'h0000000000000008;
    localparam int FRAG_ENTRY_SHIFT = 4;
    localparam logic [3:0] FRAG_ADDR_LO_OFS = 4'h0;
    localparam logic [3:0] FRAG_ADDR_HI_OFS = 4'h4;
    localparam logic [3:0] FRAG_LEN_OFS = 4'h8;

    // ============================================================
    // Header word fields
    localparam int PKT_LEN_LSB = 0;
    localparam int FRAG_CNT_LSB = 16;
    localparam int VLAN_IDX_LSB = 24;
    localparam int VLAN_INS_BIT = 30;
    localparam int DONE_IRQ_BIT = 31;

    // ============================================================
    // Tag insertion
    localparam logic [15:0] VLAN_TPID = 16'h8100;
    localparam logic [15:0] VLAN_TAG_POS = 16'h000C;

    // ============================================================
    // Host register map, byte offsets on the AHB-Lite port
    localparam logic [7:0] OFS_DESC_HI = 8'h00;
    localparam logic [7:0] OFS_DESC_LO = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_INT_STAT = 8'h0C;
    localparam logic [7:0] OFS_INT_MASK = 8'h10;
    localparam logic [7:0] OFS_MEM_ADDR = 8'h14;
    localparam logic [7:0] OFS_MEM_DATA = 8'h18;
    localparam int INT_DONE_BIT = 0;
    localparam int INT_DROP_BIT = 1;
    localparam logic [1:0] INT_MASK_RESET = 2'h0;
    localparam int MEM_AW = 8;
    localparam int MEM_WORDS = 256;

    typedef enum logic [2:0]
    {
        S_IDLE = 3'b000,
        S_HDR = 3'b001,
        S_FLO = 3'b010,
        S_FHI = 3'b011,
        S_FLEN = 3'b100,
        S_CHECK = 3'b101,
        S_DATA = 3'b110,
        S_TAG = 3'b111
    } tdf_state_t;
endpackage

// ### verilog/tdf_if.sv
// Link between the descriptor fetch engine and the host end.
// Assumes both ends run on the same hclk; every signal is synchronous to it.
interface tdf_if;
    logic reg_wr;
    logic reg_hi;
    logic [31:0] reg_wdata;
    logic rd_req;
    logic [63:0] rd_addr;
    logic rd_ack;
    logic [31:0] rd_data;
    logic [tdf_pkg::CNT_W-1:0] cmd_cnt;
    logic busy;
    logic done_evt;
    logic drop_evt;

    modport dev
    (
        input reg_wr, reg_hi, reg_wdata, rd_ack, rd_data,
        output rd_req, rd_addr, cmd_cnt, busy, done_evt, drop_evt
    );
    modport host
    (
        output reg_wr, reg_hi, reg_wdata, rd_ack, rd_data,
        input rd_req, rd_addr, cmd_cnt, busy, done_evt, drop_evt
    );
endinterface

// ### verilog/tdf_host.sv
// Host end: AHB-Lite register slave, descriptor memory and interrupt logic.
// Assumes single whole-word AHB-Lite transfers and that this slave's hreadyout is the bus hready.
module tdf_host
    import tdf_pkg::*;
(
    input logic hclk,
    input logic hresetn,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    tdf_if.host link
);
    typedef struct packed {
        logic ph_valid;
        logic ph_write;
        logic [7:0] ph_addr;
        logic [31:0] hrdata;
        logic reg_wr;
        logic reg_hi;
        logic [31:0] reg_wdata;
        logic [1:0] stat;
        logic [1:0] mask;
        logic [MEM_AW-1:0] mem_addr;
        logic [MEM_WORDS-1:0][31:0] mem;
        logic rd_ack;
        logic [31:0] rd_data;
        logic irq;
    } tdf_host_t;

    tdf_host_t r;
    tdf_host_t n;

    function automatic logic [31:0] tdf_read_mux(input tdf_host_t s, input logic [7:0] a,
                                                 input logic [CNT_W-1:0] cnt, input logic busy);
        case (a)
            OFS_STATUS: tdf_read_mux = {27'h0000000, busy, cnt};
            OFS_INT_STAT: tdf_read_mux = {30'h00000000, s.stat};
            OFS_INT_MASK: tdf_read_mux = {30'h00000000, s.mask};
            OFS_MEM_ADDR: tdf_read_mux = {24'h000000, s.mem_addr};
            OFS_MEM_DATA: tdf_read_mux = s.mem[s.mem_addr];
            default: tdf_read_mux = 32'h00000000;
        endcase
    endfunction

    // ============================================================
    // Next state
    always_comb
    begin
        n = r;
        n.reg_wr = 1'b0;
        n.rd_ack = 1'b0;
        n.ph_valid = hsel && htrans[1] && hready;
        n.ph_addr = haddr[7:0];
        n.ph_write = hwrite;
        if (n.ph_valid && !hwrite)
        begin
            n.hrdata = tdf_read_mux(r, haddr[7:0], link.cmd_cnt, link.busy);
        end
        if (r.ph_valid && r.ph_write)
        begin
            case (r.ph_addr)
                OFS_DESC_HI:
                begin
                    n.reg_wr = 1'b1;
                    n.reg_hi = 1'b1;
                    n.reg_wdata = hwdata;
                end
                OFS_DESC_LO:
                begin
                    n.reg_wr = 1'b1;
                    n.reg_hi = 1'b0;
                    n.reg_wdata = hwdata;
                end
                OFS_INT_STAT: n.stat = r.stat & ~hwdata[1:0];
                OFS_INT_MASK: n.mask = hwdata[1:0];
                OFS_MEM_ADDR: n.mem_addr = hwdata[MEM_AW-1:0];
                OFS_MEM_DATA:
                begin
                    n.mem[r.mem_addr] = hwdata;
                    n.mem_addr = r.mem_addr + 1'b1;
                end
                default: ;
            endcase
        end
        // Events set after the clear so a simultaneous event is kept.
        if (link.done_evt)
        begin
            n.stat[INT_DONE_BIT] = 1'b1;
        end
        if (link.drop_evt)
        begin
            n.stat[INT_DROP_BIT] = 1'b1;
        end
        n.irq = |(n.stat & n.mask);
        // Memory answers each fetch one cycle after the request is seen.
        if (link.rd_req && !r.rd_ack)
        begin
            n.rd_ack = 1'b1;
            n.rd_data = r.mem[link.rd_addr[MEM_AW+1:2]];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r <= '0;
            r.mask <= INT_MASK_RESET;
        end
        else
        begin
            r <= n;
        end
    end

    // ============================================================
    // Outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r.hrdata;
    assign irq = r.irq;
    assign link.reg_wr = r.reg_wr;
    assign link.reg_hi = r.reg_hi;
    assign link.reg_wdata = r.reg_wdata;
    assign link.rd_ack = r.rd_ack;
    assign link.rd_data = r.rd_data;
endmodule

// ### verilog/tdf_dev.sv
// Transmit descriptor fetch engine: command queue, descriptor walk, gather and tag insertion.
// Assumes the host end answers each fetch with one rd_ack pulse and the MAC drains tx bytes.
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
module tdf_dev
    import tdf_pkg::*;
(
    input logic hclk,
    input logic hresetn,
    tdf_if.dev link,
    output logic tx_len_valid,
    output logic [15:0] tx_len,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    input logic tx_ready,
    output logic tx_drop,
    output logic [5:0] vlan_tbl_idx,
    input logic [15:0] vlan_tci
);
    typedef struct packed {
        tdf_state_t st;
        logic [CMD_DEPTH-1:0][63:0] fifo;
        logic [2:0] wp;
        logic [2:0] rp;
        logic [CNT_W-1:0] cnt;
        logic [31:0] hi;
        logic [63:0] desc;
        logic [15:0] pkt_len;
        logic [4:0] nfrag;
        logic [5:0] vidx;
        logic vins;
        logic dirq;
        logic [4:0] fi;
        logic [MAX_FRAGS-1:0][63:0] faddr;
        logic [MAX_FRAGS-1:0][15:0] flen;
        logic [16:0] sum;
        logic [15:0] boff;
        logic [15:0] sent;
        logic [1:0] tagi;
        logic tag_done;
        logic [31:0] tag;
        logic rd_req;
        logic [63:0] rd_addr;
        logic tx_valid;
        logic [7:0] tx_byte;
        logic len_valid;
        logic [15:0] len;
        logic done_evt;
        logic drop_evt;
    } tdf_dev_t;

    tdf_dev_t r;
    tdf_dev_t n;
    logic push;
    logic pop;
    logic hold;

    function automatic logic [63:0] tdf_entry_addr(input logic [63:0] base, input logic [4:0] idx,
                                                   input logic [3:0] ofs);
        tdf_entry_addr = base + HDR_BYTES + ({59'h0, idx} << FRAG_ENTRY_SHIFT) + {60'h0, ofs};
    endfunction

    function automatic logic [7:0] tdf_pick_byte(input logic [31:0] data, input logic [1:0] lane);
        tdf_pick_byte = 8'(data >> {lane, 3'b000});
    endfunction

    // ============================================================
    // Next state
    always_comb
    begin
        n = r;
        n.len_valid = 1'b0;
        n.done_evt = 1'b0;
        n.drop_evt = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        hold = r.tx_valid && !tx_ready;
        if (r.tx_valid && tx_ready)
        begin
            n.tx_valid = 1'b0;
        end

        // High dword is only stored; the queue is untouched.
        if (link.reg_wr && link.reg_hi)
        begin
            n.hi = link.reg_wdata;
        end
        // A full queue silently ignores further low-dword writes.
        if (link.reg_wr && !link.reg_hi && r.cnt != CNT_W'(CMD_DEPTH))
        begin
            push = 1'b1;
            n.fifo[r.wp] = {r.hi, link.reg_wdata};
            n.wp = r.wp + 3'd1;
        end

        case (r.st)
            S_IDLE:
            begin
                if (r.cnt != '0)
                begin
                    n.desc = r.fifo[r.rp];
                    n.st = S_HDR;
                    n.sum = '0;
                    n.fi = '0;
                    n.boff = '0;
                    n.sent = '0;
                    n.tagi = '0;
                    n.tag_done = 1'b0;
                end
            end
            S_HDR:
            begin
                if (!r.rd_req)
                begin
                    n.rd_req = 1'b1;
                    n.rd_addr = r.desc;
                end
                else if (link.rd_ack)
                begin
                    n.rd_req = 1'b0;
                    n.pkt_len = link.rd_data[PKT_LEN_LSB +: 16];
                    n.nfrag = link.rd_data[FRAG_CNT_LSB +: 5];
                    n.vidx = link.rd_data[VLAN_IDX_LSB +: 6];
                    n.vins = link.rd_data[VLAN_INS_BIT];
                    n.dirq = link.rd_data[DONE_IRQ_BIT];
                    n.st = (link.rd_data[FRAG_CNT_LSB +: 5] == 5'd0) ? S_CHECK : S_FLO;
                end
            end
            S_FLO:
            begin
                if (!r.rd_req)
                begin
                    n.rd_req = 1'b1;
                    n.rd_addr = tdf_entry_addr(r.desc, r.fi, FRAG_ADDR_LO_OFS);
                end
                else if (link.rd_ack)
                begin
                    n.rd_req = 1'b0;
                    n.faddr[r.fi][31:0] = link.rd_data;
                    n.st = S_FHI;
                end
            end
            S_FHI:
            begin
                if (!r.rd_req)
                begin
                    n.rd_req = 1'b1;
                    n.rd_addr = tdf_entry_addr(r.desc, r.fi, FRAG_ADDR_HI_OFS);
                end
                else if (link.rd_ack)
                begin
                    n.rd_req = 1'b0;
                    n.faddr[r.fi][63:32] = link.rd_data;
                    n.st = S_FLEN;
                end
            end
            S_FLEN:
            begin
                if (!r.rd_req)
                begin
                    n.rd_req = 1'b1;
                    n.rd_addr = tdf_entry_addr(r.desc, r.fi, FRAG_LEN_OFS);
                end
                else if (link.rd_ack)
                begin
                    n.rd_req = 1'b0;
                    n.flen[r.fi] = link.rd_data[15:0];
                    n.sum = r.sum + {1'b0, link.rd_data[15:0]};
                    if (r.fi == r.nfrag - 5'd1)
                    begin
                        n.fi = '0;
                        n.st = S_CHECK;
                    end
                    else
                    begin
                        n.fi = r.fi + 5'd1;
                        n.st = S_FLO;
                    end
                end
            end
            S_CHECK:
            begin
                if (r.pkt_len == 16'h0000 || r.pkt_len > MAX_PKT_LEN || r.sum != {1'b0, r.pkt_len})
                begin
                    n.drop_evt = 1'b1;
                    pop = 1'b1;
                    n.st = S_IDLE;
                end
                else
                begin
                    n.len_valid = 1'b1;
                    n.len = r.pkt_len;
                    n.tag = {VLAN_TPID, vlan_tci};
                    n.st = S_DATA;
                end
            end
            S_DATA:
            begin
                if (!hold)
                begin
                    if (r.vins && !r.tag_done && r.sent == VLAN_TAG_POS)
                    begin
                        n.st = S_TAG;
                    end
                    else if (r.boff == r.flen[r.fi])
                    begin
                        if (r.fi == r.nfrag - 5'd1)
                        begin
                            pop = 1'b1;
                            n.done_evt = r.dirq;
                            n.st = S_IDLE;
                        end
                        else
                        begin
                            n.fi = r.fi + 5'd1;
                            n.boff = '0;
                        end
                    end
                    else if (!r.rd_req)
                    begin
                        n.rd_req = 1'b1;
                        n.rd_addr = r.faddr[r.fi] + {48'h0, r.boff};
                    end
                    else if (link.rd_ack)
                    begin
                        n.rd_req = 1'b0;
                        n.tx_byte = tdf_pick_byte(link.rd_data, r.rd_addr[1:0]);
                        n.tx_valid = 1'b1;
                        n.boff = r.boff + 16'h0001;
                        n.sent = r.sent + 16'h0001;
                    end
                end
            end
            S_TAG:
            begin
                if (!hold)
                begin
                    n.tx_valid = 1'b1;
                    n.tx_byte = r.tag[31:24];
                    n.tag = {r.tag[23:0], 8'h00};
                    n.tagi = r.tagi + 2'd1;
                    if (r.tagi == 2'd3)
                    begin
                        n.tag_done = 1'b1;
                        n.st = S_DATA;
                    end
                end
            end
            default: n.st = S_IDLE;
        endcase

        if (pop)
        begin
            n.rp = r.rp + 3'd1;
        end
        n.cnt = r.cnt + CNT_W'(push) - CNT_W'(pop);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    // ============================================================
    // Outputs
    assign link.rd_req = r.rd_req;
    assign link.rd_addr = {r.rd_addr[63:2], 2'b00};
    assign link.cmd_cnt = r.cnt;
    assign link.busy = (r.st != S_IDLE);
    assign link.done_evt = r.done_evt;
    assign link.drop_evt = r.drop_evt;
    assign tx_len_valid = r.len_valid;
    assign tx_len = r.len;
    assign tx_valid = r.tx_valid;
    assign tx_byte = r.tx_byte;
    assign tx_drop = r.drop_evt;
    assign vlan_tbl_idx = r.vidx;
endmodule

// ### tb/tdf_monitor.sv
// Checker for the link between the descriptor fetch engine and the host end.
// Assumes one clock and the link signals wired in by name as plain inputs.
module tdf_monitor
    import tdf_pkg::*;
(
    input logic hclk,
    input logic hresetn,
    input logic reg_wr,
    input logic reg_hi,
    input logic [31:0] reg_wdata,
    input logic rd_req,
    input logic [63:0] rd_addr,
    input logic rd_ack,
    input logic [CNT_W-1:0] cmd_cnt,
    input logic busy,
    input logic done_evt,
    input logic drop_evt
);
    timeunit 1ns;
    timeprecision 1ns;
    // ============================================================
    // Helper state: the held high dword and the address that an idle, empty engine fetches first.
    logic [31:0] hi_h;
    logic [63:0] exp_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hi_h <= 32'h0;
            exp_r <= 64'h0;
        end
        else
        begin
            if (reg_wr && reg_hi)
                hi_h <= reg_wdata;
            if (reg_wr && !reg_hi && !busy && cmd_cnt == 4'h0)
                exp_r <= {hi_h, reg_wdata};
        end
    end

    // ============================================================
    // Properties
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_hi_no_push:
        assert property (reg_wr && reg_hi |=> cmd_cnt <= $past(cmd_cnt)) else $error("high dword write grew queue");
    a_lo_push:
        assert property (reg_wr && !reg_hi && cmd_cnt < 4'h8 |=> cmd_cnt != 4'h0) else $error("low write not queued");
    a_lo_fetch:
        assert property (reg_wr && !reg_hi && !busy && cmd_cnt == 4'h0 |=> ##[0:7] (rd_req && rd_addr == exp_r))
        else $error("descriptor fetch address wrong");
    a_req_hold:
        assert property (rd_req && !rd_ack |=> rd_req && $stable(rd_addr)) else $error("fetch dropped before answer");
    a_cnt_bound:
        assert property (cmd_cnt <= 4'h8) else $error("queue count above depth");
    a_drop_next:
        assert property (drop_evt && cmd_cnt >= 4'h2 |-> ##[1:8] rd_req) else $error("stalled after drop");
    a_drop_nodone:
        assert property (!(drop_evt && done_evt)) else $error("dropped packet reported done");
    a_idle_noreq:
        assert property (!busy |-> !rd_req) else $error("fetch without command");
endmodule

// ### tb/tx_descriptor_fetch_test.sv
// Self-checking bench: host end and fetch engine joined by the link interface.
// Assumes little-endian byte lanes in the host memory and a combinational tag table.
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin error_cnt++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module tx_descriptor_fetch_test
    import tdf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'h0;
    logic hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, tx_ready, rdy_en;
    logic tx_len_valid, tx_valid, tx_drop;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rdv, dhi;
    logic [31:0] mem_m [0:255];
    logic [15:0] tx_len, vlan_tci;
    logic [7:0] tx_byte;
    logic [5:0] vlan_tbl_idx;
    logic [63:0] e64;
    logic [8:0] e9;
    logic [15:0] e16;
    logic [63:0] fq[$];
    logic [15:0] lq[$];
    logic [7:0] bq[$];
    int error_cnt = 0;
    int check_count = 0;
    int drop_exp = 0;

    tdf_if link ();
    tdf_host i_tdf_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .irq(irq), .link(link));
    tdf_dev i_tdf_dev (.hclk(hclk), .hresetn(hresetn), .link(link), .tx_len_valid(tx_len_valid),
        .tx_len(tx_len), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .tx_drop(tx_drop),
        .vlan_tbl_idx(vlan_tbl_idx), .vlan_tci(vlan_tci));
    tdf_monitor i_tdf_monitor (.hclk(hclk), .hresetn(hresetn), .reg_wr(link.reg_wr), .reg_hi(link.reg_hi),
        .reg_wdata(link.reg_wdata), .rd_req(link.rd_req), .rd_addr(link.rd_addr), .rd_ack(link.rd_ack),
        .cmd_cnt(link.cmd_cnt), .busy(link.busy), .done_evt(link.done_evt), .drop_evt(link.drop_evt));

    // ============================================================
    // Clock, bus slave ready, tag table and a stalling MAC.
    always #50 hclk = ~hclk;
    assign hready = hreadyout;
    assign vlan_tci = {4'hA, vlan_tbl_idx, vlan_tbl_idx};
    always @(posedge hclk)
        tx_ready <= rdy_en & 1'($urandom());

    // ============================================================
    // Bus tasks
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'h1)
            @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'h1)
            @(posedge hclk);
        rdv = hrdata;
        `CHK("hresp", 1'h0, hresp)
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        rdv = 32'h1;
        repeat (4) @(posedge hclk);
        while (rdv[4:0] !== 5'h00 && n < 5000)
        begin
            ahb(1'h0, OFS_STATUS, 32'h0);
            n++;
        end
        `CHK("idle", 5'h00, rdv[4:0])
        repeat (2) @(posedge hclk);
    endtask

    // ============================================================
    // Expected fetches, length, bytes and drops of one descriptor.
    task automatic expect_pkt(input logic [63:0] da);
        logic [31:0] h;
        logic [63:0] b, a;
        logic [63:0] fa [0:30];
        logic [15:0] fl [0:30];
        logic [15:0] t;
        int sum, k;
        h = mem_m[da[9:2]];
        t = {4'hA, h[29:24], h[29:24]};
        sum = 0;
        k = 0;
        fq.push_back(da);
        for (int i = 0; i < int'(h[20:16]); i++)
        begin
            b = da + 64'h8 + 64'(16 * i);
            fq.push_back(b);
            fq.push_back(b + 64'h4);
            fq.push_back(b + 64'h8);
            fa[i] = {mem_m[b[9:2] + 8'h1], mem_m[b[9:2]]};
            fl[i] = mem_m[b[9:2] + 8'h2][15:0];
            sum += int'(fl[i]);
        end
        if (h[15:0] == 16'h0 || h[15:0] > MAX_PKT_LEN || sum != int'(h[15:0]))
            drop_exp++;
        else
        begin
            lq.push_back(h[15:0]);
            for (int i = 0; i < int'(h[20:16]); i++)
                for (int j = 0; j < int'(fl[i]); j++)
                begin
                    a = fa[i] + 64'(j);
                    fq.push_back({a[63:2], 2'h0});
                    bq.push_back(8'(mem_m[a[9:2]] >> (8 * a[1:0])));
                    k++;
                    if (h[VLAN_INS_BIT] && k == int'(VLAN_TAG_POS))
                    begin
                        bq.push_back(VLAN_TPID[15:8]);
                        bq.push_back(VLAN_TPID[7:0]);
                        bq.push_back(t[15:8]);
                        bq.push_back(t[7:0]);
                    end
                end
        end
    endtask

    task automatic push(input logic [31:0] lo);
        expect_pkt({dhi, lo});
        ahb(1'h1, OFS_DESC_LO, lo);
    endtask

    task automatic frag(input logic [7:0] w, input logic [31:0] lo, input logic [31:0] hi, input logic [15:0] len);
        mem_m[w] = lo;
        mem_m[w + 8'h1] = hi;
        mem_m[w + 8'h2] = {16'h0, len};
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ============================================================
    // Observer: each result takes the oldest note of its kind.
    always @(posedge hclk)
    begin
        if (hresetn === 1'h1)
        begin
            if (link.rd_req === 1'h1 && link.rd_ack === 1'h1)
            begin
                e64 = (fq.size() > 0) ? fq.pop_front() : 64'h0;
                `CHK("fetch addr", e64, link.rd_addr)
            end
            if (tx_len_valid === 1'h1)
            begin
                e16 = (lq.size() > 0) ? lq.pop_front() : 16'h0;
                `CHK("tx len", e16, tx_len)
            end
            if (tx_valid === 1'h1 && tx_ready === 1'h1)
            begin
                e9 = (bq.size() > 0) ? {1'h0, bq.pop_front()} : 9'h100;
                `CHK("tx byte", e9, {1'h0, tx_byte})
            end
            if (tx_drop === 1'h1)
            begin
                `CHK("drop", 1'h1, drop_exp > 0)
                drop_exp--;
            end
        end
    end

    initial
    begin
        repeat (40000) @(posedge hclk);
        error_cnt++;
        end_sim();
    end

    // ============================================================
    // Main sequence
    initial
    begin
        hresetn = 1'h0;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        rdy_en = 1'h0;
        dhi = 32'h7;
        void'($urandom(9));
        for (int i = 0; i < 256; i++)
            mem_m[i] = (i >= 16 && i < 64) ? 32'h0 : $urandom();
        mem_m[8'h10] = 32'hC503000E;
        frag(8'h12, 32'h201, 32'h1, 16'hA);
        frag(8'h16, 32'h3F0, 32'h0, 16'h0);
        frag(8'h1A, 32'h300, 32'h0, 16'h4);
        mem_m[8'h20] = 32'h00010005;
        frag(8'h22, 32'h310, 32'h0, 16'h4);
        mem_m[8'h28] = 32'h00010000;
        frag(8'h2A, 32'h320, 32'h0, 16'h0);
        mem_m[8'h30] = 32'h00018001;
        frag(8'h32, 32'h330, 32'h0, 16'h8001);
        mem_m[8'h38] = 32'h00010003;
        frag(8'h3A, 32'h2FE, 32'h3, 16'h3);
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        for (int i = 0; i < 5; i++)
        begin
            ahb(1'h0, (i == 4) ? 8'h1C : 8'(i * 4), 32'h0);
            `CHK("reset read", 32'h0, rdv)
        end
        ahb(1'h1, OFS_MEM_ADDR, 32'h0);
        for (int i = 0; i < 256; i++)
            ahb(1'h1, OFS_MEM_DATA, mem_m[i]);
        ahb(1'h1, OFS_MEM_ADDR, 32'h10);
        ahb(1'h0, OFS_MEM_DATA, 32'h0);
        `CHK("mem read", mem_m[16], rdv)
        ahb(1'h1, OFS_INT_MASK, 32'h1);
        ahb(1'h1, OFS_DESC_HI, dhi);
        for (int i = 0; i < 8; i++)
            push(32'h40);
        ahb(1'h1, OFS_DESC_LO, 32'h40);
        ahb(1'h1, OFS_DESC_HI, 32'h9);
        repeat (4) @(posedge hclk);
        ahb(1'h0, OFS_STATUS, 32'h0);
        `CHK("status full", 32'h00000018, rdv)
        rdy_en <= 1'h1;
        wait_idle();
        `CHK("irq done", 1'h1, irq)
        ahb(1'h0, OFS_INT_STAT, 32'h0);
        `CHK("int stat done", 32'h1, rdv)
        ahb(1'h1, OFS_INT_STAT, 32'h1);
        ahb(1'h0, OFS_INT_STAT, 32'h0);
        `CHK("irq cleared", 1'h0, irq)
        dhi = 32'h2;
        ahb(1'h1, OFS_DESC_HI, dhi);
        for (int i = 0; i < 4; i++)
            push(32'h80 + 32'(i * 32));
        wait_idle();
        ahb(1'h0, OFS_INT_STAT, 32'h0);
        `CHK("int stat drop", 32'h2, rdv)
        `CHK("irq masked", 1'h0, irq)
        ahb(1'h1, OFS_INT_MASK, 32'h3);
        repeat (2) @(posedge hclk);
        `CHK("irq drop", 1'h1, irq)
        ahb(1'h1, OFS_INT_STAT, 32'h2);
        repeat (2) @(posedge hclk);
        `CHK("irq drop cleared", 1'h0, irq)
        `CHK("pending notes", 0, fq.size() + lq.size() + bq.size() + drop_exp)
        end_sim();
    end
endmodule
